// [test_usb_host_transfer_descriptor.sv]
// self-checking testbench for the transfer descriptor engine
`timescale 1ns/100ps
`default_nettype none

module test_usb_host_transfer_descriptor;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [6:0]  avs_address = 7'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        frame_tick = 1'b0;
  logic        txn_req, txn_low_speed, txn_data_toggle, txn_iso, txn_done;
  logic [1:0]  txn_token_direction_code;
  logic [6:0]  txn_target_device_addr;
  logic [3:0]  txn_endpoint_index, txn_code;
  logic [9:0]  txn_len, txn_bytes;
  logic [3:0]  rsp_code = 4'h0;
  logic        rsp_over = 1'b0;
  logic        rsp_slow = 1'b0;
  logic [25:0] cap = 26'h0;
  logic [31:0] rd;
  logic [3:0]  codes [11] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
                              4'hc, 4'hd};
  int          bad_count = 0;
  int          checks = 0;
  int          req_cnt = 0;
  int          done_cnt = 0;
  int          f;

  always #5 core_clk = ~core_clk;

  uhtd_engine dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .frame_tick(frame_tick), .txn_req(txn_req),
    .txn_token_direction_code(txn_token_direction_code),
    .txn_target_device_addr(txn_target_device_addr),
    .txn_endpoint_index(txn_endpoint_index), .txn_low_speed(txn_low_speed),
    .txn_data_toggle(txn_data_toggle), .txn_len(txn_len), .txn_iso(txn_iso),
    .txn_done(txn_done), .txn_code(txn_code), .txn_bytes(txn_bytes));

  uhtd_usb_dev dev (.core_clk(core_clk), .rst(rst), .txn_req(txn_req),
    .txn_len(txn_len), .rsp_code(rsp_code), .rsp_over(rsp_over),
    .rsp_slow(rsp_slow), .txn_done(txn_done), .txn_code(txn_code),
    .txn_bytes(txn_bytes));

  // capture each requested transaction and count answers
  always @(posedge core_clk) begin
    if (txn_req === 1'b1) begin
      req_cnt <= req_cnt + 1;
      cap <= {txn_token_direction_code, txn_target_device_addr, txn_endpoint_index,
              txn_low_speed, txn_data_toggle, txn_len, txn_iso};
    end
    if (txn_done === 1'b1) begin
      done_cnt <= done_cnt + 1;
    end
  end

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d);
    int i;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 40);
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      test_done;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(e, rd);
  endtask

  // one frame; counts the transactions it starts
  task automatic tick(input int n_exp);
    int n;
    int i;
    n = req_cnt;
    frame_tick <= 1'b1;
    @(posedge core_clk);
    frame_tick <= 1'b0;
    for (i = 0; i < 80 && req_cnt == n; i++) @(posedge core_clk);
    if (n_exp > 0) begin
      for (i = 0; i < 40 && done_cnt != req_cnt; i++) @(posedge core_clk);
      if (req_cnt == n || done_cnt != req_cnt) begin
        bad_count++;
        test_done;
      end
      repeat (8) @(posedge core_clk);
    end
    chk(n_exp, req_cnt - n);
  endtask

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rchk(7'h00, 32'h0);
    bus(1'b1, 7'h10, 32'hffff_ffff);
    rchk(7'h10, 32'h0);
    bus(1'b1, 7'h05, 32'h0000_ffff);
    rchk(7'h05, 32'h0);
    $display("test registers done");
    // async descriptor, low speed, last flag set, reserved bit set
    bus(1'b1, 7'h40, 32'h5c08_0800);
    bus(1'b1, 7'h41, 32'h0012_2814);
    bus(1'b1, 7'h03, 32'h0);
    tick(0);
    bus(1'b1, 7'h01, 32'h1);
    bus(1'b1, 7'h00, 32'h1);
    tick(0);
    bus(1'b1, 7'h01, 32'h0);
    $display("test gating done");
    for (int k = 0; k < 3; k++) begin
      tick(1);
      chk({6'h0, 2'h2, 7'h12, 4'h5, 1'b1, k[0], (k == 2) ? 10'd4 : 10'd8, 1'b0},
          {6'h0, cap});
      if (k == 0) rchk(7'h40, 32'h5c08_0c08);
    end
    rchk(7'h40, 32'h5c08_0414);
    tick(0);
    $display("test split done");
    for (int k = 0; k < 11; k++) begin
      rsp_code <= (codes[k] == 4'h8) ? 4'h0 : codes[k];
      rsp_over <= (codes[k] == 4'h8);
      bus(1'b1, 7'h40, 32'h5c08_0800);
      tick(1);
      rchk(7'h40, {16'h5c08, codes[k], 12'h0} | {28'h0, codes[k] == 4'h8, 3'h0});
    end
    $display("test outcome done");
    rsp_code <= 4'h0;
    rsp_over <= 1'b0;
    rsp_slow <= 1'b1;
    bus(1'b0, 7'h05, 32'h0);
    f = rd[7:0] + 2;
    bus(1'b1, 7'h58, 32'h3810_0800);
    bus(1'b1, 7'h59, {f[7:0], 24'h05_0410});
    bus(1'b1, 7'h5a, 32'h4010_0800);
    bus(1'b1, 7'h5b, {f[7:0], 24'h05_0410});
    bus(1'b1, 7'h00, 32'h4);
    tick(0);
    tick(1);
    chk({6'h0, 2'h1, 7'h05, 4'h3, 1'b0, 1'b0, 10'd16, 1'b1}, {6'h0, cap});
    $display("test iso done");
    // reserved token code on the async list never runs
    bus(1'b1, 7'h40, 32'h5c08_0800);
    bus(1'b1, 7'h41, 32'h0012_2c14);
    bus(1'b1, 7'h00, 32'h1);
    tick(0);
    // periodic: every 2 frames, first due two frames on
    bus(1'b0, 7'h05, 32'h0);
    f = rd[7:0] + 2;
    bus(1'b1, 7'h50, 32'h3010_0800);
    bus(1'b1, 7'h51, {3'h1, f[4:0], 24'h05_0440});
    bus(1'b1, 7'h00, 32'h2);
    tick(0);
    tick(1);
    chk({6'h0, 2'h1, 7'h05, 4'h3, 1'b0, 1'b0, 10'd16, 1'b0}, {6'h0, cap});
    $display("test periodic done");
    // paired halves: second half stored first, first half must run first
    bus(1'b1, 7'h03, 32'h1);
    bus(1'b1, 7'h40, 32'h5c08_0800);
    bus(1'b1, 7'h41, 32'h0012_c806);
    bus(1'b1, 7'h42, 32'h5c08_0800);
    bus(1'b1, 7'h43, 32'h0012_8804);
    bus(1'b1, 7'h00, 32'h1);
    for (int k = 0; k < 2; k++) begin
      tick(1);
      chk({6'h0, 2'h2, 7'h12, 4'h5, 1'b1, 1'b0, (k == 0) ? 10'd4 : 10'd6, 1'b0},
          {6'h0, cap});
    end
    tick(0);
    $display("test paired done");
    test_done;
  end
endmodule

`default_nettype wire

// [uhtd_consts.vh]
// constants for the usb host transfer descriptor engine
`ifndef UHTD_CONSTS_VH
`define UHTD_CONSTS_VH

// ****************************************************************
// register word indices (avalon word address)
// ****************************************************************
`define UHTD_A_READY     7'h00
`define UHTD_A_ASKIP     7'h01
`define UHTD_A_PSKIP     7'h02
`define UHTD_A_AEND      7'h03
`define UHTD_A_PEND      7'h04
`define UHTD_A_FRAME     7'h05
`define UHTD_A_STATUS    7'h06
`define UHTD_A_MEM_TOP   2'b10
`define UHTD_MEM_WORDS   32

// ****************************************************************
// list_ready_reg bits and list regions (descriptor index)
// ****************************************************************
`define UHTD_RDY_ASYNC   0
`define UHTD_RDY_PER     1
`define UHTD_RDY_ISO     2
`define UHTD_ASYNC_BASE  4'h0
`define UHTD_ASYNC_LAST  4'h7
`define UHTD_PER_BASE    4'h8
`define UHTD_PER_LAST    4'hb
`define UHTD_ISO_BASE    4'hc
`define UHTD_ISO_LAST    4'hf

// ****************************************************************
// descriptor word 0 fields (bytes 0..3)
// ****************************************************************
`define UHTD_W0_ACT_HI   9
`define UHTD_W0_TOGGLE   10
`define UHTD_W0_ACTIVE   11
`define UHTD_W0_CC_LO    12
`define UHTD_W0_CC_HI    15
`define UHTD_W0_MPS_LO   16
`define UHTD_W0_MPS_HI8  23
`define UHTD_W0_MPS_B8   24
`define UHTD_W0_SPEED    26
`define UHTD_W0_LAST     27
`define UHTD_W0_EP_LO    28

// ****************************************************************
// descriptor word 1 fields (bytes 4..7)
// ****************************************************************
`define UHTD_W1_TOT_HI   9
`define UHTD_W1_DIR_LO   10
`define UHTD_W1_HALF     14
`define UHTD_W1_PAIRED   15
`define UHTD_W1_ADDR_LO  16
`define UHTD_W1_SCH_LO   24

// ****************************************************************
// codes
// ****************************************************************
`define UHTD_DIR_RSVD    2'h3
`define UHTD_CC_OK       4'h0
`define UHTD_CC_OVERRUN  4'h8

`endif

// [uhtd_desc_ram.v]
// flip-flop storage for transfer descriptors, bus and engine ports
`timescale 1ns/100ps
`default_nettype none

module uhtd_desc_ram #(
  parameter WORDS = 32,
  parameter AW    = 5
) (
  input  wire          core_clk,
  input  wire          rst,
  input  wire          bus_we,
  input  wire [AW-1:0] bus_addr,
  input  wire [31:0]   bus_wdata,
  output wire [31:0]   bus_rdata,
  input  wire          eng_we,
  input  wire [AW-1:0] eng_addr,
  input  wire [31:0]   eng_wdata,
  output wire [31:0]   eng_rdata0,
  output wire [31:0]   eng_rdata1
);
  reg [31:0] mem_reg [0:WORDS-1];
  integer i;

  // ****************************************************************
  // storage; engine write wins, the top keeps them apart
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < WORDS; i = i + 1) begin
        mem_reg[i] <= 32'h0000_0000;
      end
    end else if (eng_we) begin
      mem_reg[eng_addr] <= eng_wdata;
    end else if (bus_we) begin
      mem_reg[bus_addr] <= bus_wdata;
    end
  end

  // reads: descriptor pair sits at even/odd words
  assign bus_rdata  = mem_reg[bus_addr];
  assign eng_rdata0 = mem_reg[{eng_addr[AW-1:1], 1'b0}];
  assign eng_rdata1 = mem_reg[{eng_addr[AW-1:1], 1'b1}];
endmodule

`default_nettype wire

// [uhtd_due_check.v]
// decides whether a periodic or iso descriptor is due this frame
`timescale 1ns/100ps
`default_nettype none

module uhtd_due_check (
  input  wire [7:0] frame,
  input  wire [7:0] sched,
  input  wire       iso,
  output wire       due
);
  wire [7:0] interval_mask;
  wire [7:0] since_start;

  // poll interval of 2^rate frames, phase from start frame
  assign interval_mask = (8'h01 << sched[7:5]) - 8'h01;
  assign since_start   = frame - {3'b000, sched[4:0]};
  // iso: whole byte must equal the frame number
  assign due = iso ? (frame == sched) : ((since_start & interval_mask) == 8'h00);
endmodule

`default_nettype wire

// [uhtd_engine.v]
// usb host transfer descriptor engine: register slave and list walker
//
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "uhtd_consts.vh"

module uhtd_engine (
  input  wire        core_clk,
  input  wire        rst,
  input  wire [6:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        frame_tick,
  output reg         txn_req,
  output reg  [1:0]  txn_token_direction_code,
  output reg  [6:0]  txn_target_device_addr,
  output reg  [3:0]  txn_endpoint_index,
  output reg         txn_low_speed,
  output reg         txn_data_toggle,
  output reg  [9:0]  txn_len,
  output reg         txn_iso,
  input  wire        txn_done,
  input  wire [3:0]  txn_code,
  input  wire [9:0]  txn_bytes
);
  // ****************************************************************
  // states and list selectors
  // ****************************************************************
  localparam S_IDLE  = 3'd0;
  localparam S_CHECK = 3'd1;
  localparam S_WAIT  = 3'd2;
  localparam S_WB    = 3'd3;
  localparam S_NEXT  = 3'd4;
  localparam L_ISO   = 2'd0;
  localparam L_PER   = 2'd1;
  localparam L_ASYNC = 2'd2;

  // byte-lane merge of a bus write
  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer k;
    begin
      be_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          be_merge[8*k +: 8] = wd[8*k +: 8];
        end
      end
    end
  endfunction

  reg [2:0]  list_ready_reg;
  reg [15:0] async_skip_mask_reg;
  reg [15:0] periodic_skip_mask_reg;
  reg [3:0]  async_list_end_reg;
  reg [3:0]  periodic_list_end_reg;
  reg [15:0] frame_count_reg;
  reg        scan_pending_reg;
  reg [2:0]  state_reg;
  reg [1:0]  list_reg;
  reg [3:0]  idx_reg;
  reg        pair_expect_reg;
  reg [3:0]  wb_cc_reg;
  reg [9:0]  wb_actual_reg;
  reg        wb_toggle_reg;
  reg        wb_finish_reg;

  wire [31:0] w0;
  wire [31:0] w1;
  wire [31:0] mem_bus_rdata;
  wire        due;
  wire        bus_cmd;
  wire        bus_commit;
  wire        mem_hit;
  wire        bus_mem_we;
  wire        eng_we;
  wire [31:0] eng_wdata;
  wire [31:0] askip_merge;
  wire [31:0] pskip_merge;

  // ****************************************************************
  // avalon slave: one wait cycle, commit when waitrequest low
  // ****************************************************************
  assign bus_cmd    = avs_read | avs_write;
  assign bus_commit = bus_cmd & ~avs_waitrequest;
  assign mem_hit    = (avs_address[6:5] == `UHTD_A_MEM_TOP);
  assign bus_mem_we = bus_commit & avs_write & mem_hit;
  // engine write-back yields to a committing bus write
  assign eng_we     = (state_reg == S_WB) & ~bus_mem_we;
  // skip masks keep only the low half of the lane-merged word
  assign askip_merge = be_merge({16'h0, async_skip_mask_reg}, avs_writedata,
                                avs_byteenable);
  assign pskip_merge = be_merge({16'h0, periodic_skip_mask_reg}, avs_writedata,
                                avs_byteenable);

  uhtd_desc_ram #(
    .WORDS (`UHTD_MEM_WORDS),
    .AW    (5)
  ) u_ram (
    .core_clk   (core_clk),
    .rst        (rst),
    .bus_we     (bus_mem_we),
    .bus_addr   (avs_address[4:0]),
    .bus_wdata  (be_merge(mem_bus_rdata, avs_writedata, avs_byteenable)),
    .bus_rdata  (mem_bus_rdata),
    .eng_we     (eng_we),
    .eng_addr   ({idx_reg, 1'b0}),
    .eng_wdata  (eng_wdata),
    .eng_rdata0 (w0),
    .eng_rdata1 (w1)
  );

  uhtd_due_check u_due (
    .frame (frame_count_reg[7:0]),
    .sched (w1[31:`UHTD_W1_SCH_LO]),
    .iso   (list_reg == L_ISO),
    .due   (due)
  );

  // read mux; unmapped words read zero
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    if (mem_hit) begin
      rd_mux = mem_bus_rdata;
    end else begin
      case (avs_address)
        `UHTD_A_READY:  rd_mux = {29'h0, list_ready_reg};
        `UHTD_A_ASKIP:  rd_mux = {16'h0, async_skip_mask_reg};
        `UHTD_A_PSKIP:  rd_mux = {16'h0, periodic_skip_mask_reg};
        `UHTD_A_AEND:   rd_mux = {28'h0, async_list_end_reg};
        `UHTD_A_PEND:   rd_mux = {28'h0, periodic_list_end_reg};
        `UHTD_A_FRAME:  rd_mux = {16'h0, frame_count_reg};
        `UHTD_A_STATUS: rd_mux = {20'h0, pair_expect_reg, state_reg, 2'b00, list_reg, idx_reg};
        default:        rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // handshake and control registers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      avs_waitrequest        <= 1'b1;
      avs_readdata           <= 32'h0000_0000;
      list_ready_reg         <= 3'h0;
      async_skip_mask_reg    <= 16'h0000;
      periodic_skip_mask_reg <= 16'h0000;
      async_list_end_reg     <= 4'h0;
      periodic_list_end_reg  <= 4'h0;
    end else begin
      if (bus_commit) begin
        avs_waitrequest <= 1'b1;
      end else if (bus_cmd) begin
        avs_waitrequest <= 1'b0;
        avs_readdata    <= rd_mux;
      end
      if (bus_commit && avs_write && !mem_hit) begin
        case (avs_address)
          `UHTD_A_READY: list_ready_reg <= avs_byteenable[0] ? avs_writedata[2:0] : list_ready_reg;
          `UHTD_A_ASKIP: async_skip_mask_reg <= askip_merge[15:0];
          `UHTD_A_PSKIP: periodic_skip_mask_reg <= pskip_merge[15:0];
          `UHTD_A_AEND:  async_list_end_reg <= avs_byteenable[0] ? avs_writedata[3:0] : async_list_end_reg;
          `UHTD_A_PEND:  periodic_list_end_reg <= avs_byteenable[0] ? avs_writedata[3:0] : periodic_list_end_reg;
          default:       list_ready_reg <= list_ready_reg;
        endcase
      end
    end
  end

  // ****************************************************************
  // descriptor field decode
  // ****************************************************************
  wire [9:0] f_actual = w0[`UHTD_W0_ACT_HI:0];
  wire [9:0] f_mps    = {w0[`UHTD_W0_MPS_B8+1:`UHTD_W0_MPS_B8], w0[`UHTD_W0_MPS_HI8:`UHTD_W0_MPS_LO]};
  wire [9:0] f_total  = w1[`UHTD_W1_TOT_HI:0];
  wire [1:0] f_dir    = w1[`UHTD_W1_DIR_LO+1:`UHTD_W1_DIR_LO];
  wire [9:0] f_remain = f_total - f_actual;
  // split: each packet is the smaller of what is left and the maximum
  wire [9:0] f_len    = (f_remain > f_mps) ? f_mps : f_remain;

  // list-ready, skip and end, per list
  reg        lst_ready;
  reg        lst_skip;
  reg        lst_end;
  always @* begin
    lst_ready = 1'b0;
    lst_skip  = 1'b0;
    lst_end   = 1'b1;
    case (list_reg)
      L_ISO: begin
        lst_ready = list_ready_reg[`UHTD_RDY_ISO];
        lst_end   = w0[`UHTD_W0_LAST] | (idx_reg == `UHTD_ISO_LAST);
      end
      L_PER: begin
        lst_ready = list_ready_reg[`UHTD_RDY_PER];
        lst_skip  = periodic_skip_mask_reg[idx_reg - `UHTD_PER_BASE];
        lst_end   = (idx_reg - `UHTD_PER_BASE == periodic_list_end_reg) |
                    (idx_reg == `UHTD_PER_LAST);
      end
      L_ASYNC: begin
        lst_ready = list_ready_reg[`UHTD_RDY_ASYNC];
        lst_skip  = async_skip_mask_reg[idx_reg - `UHTD_ASYNC_BASE];
        lst_end   = (idx_reg - `UHTD_ASYNC_BASE == async_list_end_reg) |
                    (idx_reg == `UHTD_ASYNC_LAST);
      end
      default: begin
        lst_ready = 1'b0;
      end
    endcase
  end

  // paired halves only on the async list, taken in order
  wire pair_ok = (list_reg != L_ASYNC) | ~w1[`UHTD_W1_PAIRED] |
                 (w1[`UHTD_W1_HALF] == pair_expect_reg);
  wire eligible = w0[`UHTD_W0_ACTIVE] & ~lst_skip & (f_dir != `UHTD_DIR_RSVD) &
                  (due | list_reg == L_ASYNC) & pair_ok;

  // outcome of a finished packet
  wire       over      = txn_bytes > txn_len;
  wire [3:0] res_code  = over ? `UHTD_CC_OVERRUN : txn_code;
  wire [9:0] res_bytes = over ? txn_len : txn_bytes;
  wire [9:0] res_act   = f_actual + res_bytes;
  wire       res_ok    = (res_code == `UHTD_CC_OK);

  // write-back image of word 0; reserved and fixed fields untouched
  assign eng_wdata = {w0[31:`UHTD_W0_CC_HI+1], wb_cc_reg, ~wb_finish_reg & w0[`UHTD_W0_ACTIVE],
                      wb_toggle_reg, wb_actual_reg};

  // ****************************************************************
  // frame counter and list walker
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame_count_reg          <= 16'h0000;
      scan_pending_reg         <= 1'b0;
      state_reg                <= S_IDLE;
      list_reg                 <= L_ISO;
      idx_reg                  <= `UHTD_ISO_BASE;
      pair_expect_reg          <= 1'b0;
      wb_cc_reg                <= 4'h0;
      wb_actual_reg            <= 10'h000;
      wb_toggle_reg            <= 1'b0;
      wb_finish_reg            <= 1'b0;
      txn_req                  <= 1'b0;
      txn_token_direction_code <= 2'h0;
      txn_target_device_addr   <= 7'h00;
      txn_endpoint_index       <= 4'h0;
      txn_low_speed            <= 1'b0;
      txn_data_toggle          <= 1'b0;
      txn_len                  <= 10'h000;
      txn_iso                  <= 1'b0;
    end else begin
      txn_req <= 1'b0;
      if (frame_tick) begin
        frame_count_reg <= frame_count_reg + 16'h0001;
      end
      // tick during a scan queues the next one
      if (frame_tick) begin
        scan_pending_reg <= 1'b1;
      end else if (state_reg == S_IDLE && scan_pending_reg) begin
        scan_pending_reg <= 1'b0;
      end
      case (state_reg)
        S_IDLE: begin
          if (scan_pending_reg) begin
            list_reg  <= L_ISO;
            idx_reg   <= `UHTD_ISO_BASE;
            state_reg <= S_CHECK;
          end
        end
        S_CHECK: begin
          if (!lst_ready) begin
            state_reg <= S_NEXT;
          end else if (eligible) begin
            txn_req                  <= 1'b1;
            txn_token_direction_code <= f_dir;
            txn_target_device_addr   <= w1[`UHTD_W1_ADDR_LO+6:`UHTD_W1_ADDR_LO];
            txn_endpoint_index       <= w0[31:`UHTD_W0_EP_LO];
            txn_low_speed            <= w0[`UHTD_W0_SPEED];
            txn_data_toggle          <= w0[`UHTD_W0_TOGGLE];
            txn_len                  <= f_len;
            txn_iso                  <= (list_reg == L_ISO);
            state_reg                <= S_WAIT;
          end else begin
            state_reg <= S_NEXT;
          end
        end
        S_WAIT: begin
          if (txn_done) begin
            wb_cc_reg     <= res_code;
            wb_actual_reg <= res_act;
            wb_toggle_reg <= w0[`UHTD_W0_TOGGLE] ^ res_ok;
            // finish on error, short packet, all bytes moved, or any iso packet
            wb_finish_reg <= ~res_ok | (res_bytes < txn_len) | (res_act >= f_total) |
                             (list_reg == L_ISO);
            state_reg     <= S_WB;
          end
        end
        S_WB: begin
          if (eng_we) begin
            if (list_reg == L_ASYNC && w1[`UHTD_W1_PAIRED] && wb_finish_reg) begin
              pair_expect_reg <= ~pair_expect_reg;
            end
            state_reg <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (!lst_ready || lst_end) begin
            case (list_reg)
              L_ISO: begin
                list_reg  <= L_PER;
                idx_reg   <= `UHTD_PER_BASE;
                state_reg <= S_CHECK;
              end
              L_PER: begin
                list_reg  <= L_ASYNC;
                idx_reg   <= `UHTD_ASYNC_BASE;
                state_reg <= S_CHECK;
              end
              default: begin
                list_reg  <= L_ISO;
                idx_reg   <= `UHTD_ISO_BASE;
                state_reg <= S_IDLE;
              end
            endcase
          end else begin
            idx_reg   <= idx_reg + 4'h1;
            state_reg <= S_CHECK;
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// [uhtd_engine_checker.sv]
// port assertions for the transfer descriptor engine
`timescale 1ns/100ps
`default_nettype none

module uhtd_engine_checker (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic       txn_req,
  input wire logic [1:0] txn_token_direction_code,
  input wire logic [6:0] txn_target_device_addr,
  input wire logic [3:0] txn_endpoint_index,
  input wire logic       txn_low_speed,
  input wire logic       txn_data_toggle,
  input wire logic [9:0] txn_len,
  input wire logic       txn_done
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  logic pend_reg;

  // ****************************************************************
  // outstanding transaction tracker
  // ****************************************************************
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pend_reg <= 1'b0;
    end else if (txn_req) begin
      pend_reg <= 1'b1;
    end else if (txn_done) begin
      pend_reg <= 1'b0;
    end
  end

  // bus answer comes after exactly one wait cycle
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("waitrequest not dropped after one cycle");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  a_wait_cause: assert property ($fell(avs_waitrequest)
    |-> $past(avs_read) || $past(avs_write)) else $error("answer without request");
  // transaction request shape
  a_req_pulse: assert property (txn_req |=> !txn_req)
    else $error("transaction request wider than one cycle");
  a_no_reserved: assert property (txn_req |-> txn_token_direction_code != 2'h3)
    else $error("reserved token code issued");
  a_fields_hold: assert property (!txn_req |-> $stable({txn_token_direction_code,
    txn_target_device_addr, txn_endpoint_index, txn_low_speed, txn_data_toggle,
    txn_len})) else $error("token fields moved without a request");
  a_one_open: assert property (txn_req |-> !pend_reg)
    else $error("second request while one is open");
  a_done_gap: assert property (txn_done |=> !txn_req [*2])
    else $error("request during descriptor write-back");
endmodule

bind uhtd_engine uhtd_engine_checker u_chk (.core_clk(core_clk), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .txn_req(txn_req), .txn_token_direction_code(txn_token_direction_code),
  .txn_target_device_addr(txn_target_device_addr),
  .txn_endpoint_index(txn_endpoint_index), .txn_low_speed(txn_low_speed),
  .txn_data_toggle(txn_data_toggle), .txn_len(txn_len), .txn_done(txn_done));

`default_nettype wire

// [uhtd_usb_dev.sv]
// behavioural usb peripheral answering engine transactions
`timescale 1ns/100ps
`default_nettype none

module uhtd_usb_dev (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       txn_req,
  input  wire logic [9:0] txn_len,
  input  wire logic [3:0] rsp_code,
  input  wire logic       rsp_over,
  input  wire logic       rsp_slow,
  output var  logic       txn_done,
  output wire logic [3:0] txn_code,
  output wire logic [9:0] txn_bytes
);
  logic [4:0] cnt_reg;
  logic [9:0] len_reg;
  logic [9:0] junk_reg;

  // answer delay counter, junk pattern between answers
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_reg  <= 5'h0;
      len_reg  <= 10'h0;
      junk_reg <= 10'h155;
      txn_done <= 1'b0;
    end else begin
      junk_reg <= ~junk_reg;
      txn_done <= (cnt_reg == 5'h1);
      if (txn_req) begin
        cnt_reg <= rsp_slow ? 5'h8 : 5'h2;
        len_reg <= txn_len;
      end else if (cnt_reg != 5'h0) begin
        cnt_reg <= cnt_reg - 5'h1;
      end
    end
  end

  // error answers move no data; overrun sends surplus bytes
  assign txn_code  = txn_done ? rsp_code : junk_reg[3:0];
  assign txn_bytes = !txn_done ? junk_reg :
                     (rsp_code != 4'h0) ? 10'h0 : len_reg + {7'h0, rsp_over, 2'h0};
endmodule

`default_nettype wire
